// ==== hw/mcap_pkg.sv ====
// shared constants, carriers and decode helpers for the monitor command front end
// assumes one serial link clock from the host and a free-running system clock
package mcap_pkg;

  // ***************************************************************
  // check code
  // ***************************************************************
  localparam logic [14:0] CRC_SEED = 15'h0010;
  localparam logic [14:0] CRC_TAPS = 15'h4598;

  // ***************************************************************
  // frame layout, counted in link bits
  // ***************************************************************
  localparam int unsigned DATA_W = 48;
  localparam int unsigned GROUP_W = 64;
  localparam logic [7:0] CNT_CMD_B1_LAST = 8'h0f;
  localparam logic [7:0] CNT_CMD_LAST = 8'h1f;
  localparam logic [7:0] CNT_DATA_FIRST = 8'h20;
  localparam logic [7:0] CNT_TX_LAST = 8'h5f;
  localparam logic [7:0] CNT_GROUP_END = 8'h60;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ***************************************************************
  // command word fields
  // ***************************************************************
  localparam int unsigned POS_ADDR_FLAG = 31;
  localparam int unsigned POS_ADDR_HI = 30;
  localparam int unsigned POS_ADDR_LO = 27;
  localparam int unsigned POS_CODE_HI = 26;
  localparam int unsigned POS_CODE_LO = 16;
  localparam int unsigned POS_CHK_HI = 15;

  // ***************************************************************
  // command codes
  // ***************************************************************
  localparam logic [10:0] CC_WRITE_CFG = 11'h001;
  localparam logic [10:0] CC_WRITE_COMM = 11'h721;
  localparam logic [10:0] CC_READ_COMM = 11'h722;
  localparam logic [10:0] CC_POLL_STATUS = 11'h714;
  localparam logic [10:0] CC_DIAG_POLL = 11'h715;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef struct packed {
    logic addressed;
    logic [3:0] addr;
    logic [10:0] code;
  } mcap_cmd_t;

  typedef struct packed {
    logic chk_ok;
    logic accepted;
    logic reply_ok;
  } mcap_dec_t;

  typedef struct packed {
    logic iso;
    logic chain;
    logic [3:0] addr;
  } mcap_strap_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SPI_POLL = 3'b010,
    ST_ISO_POLL = 3'b100
  } mcap_poll_t;

  function automatic logic [14:0] crc15_step(input logic [14:0] crc, input logic din);
    logic in0;
    in0 = din ^ crc[14];
    crc15_step = {crc[13:0], in0} ^ ({15{in0}} & CRC_TAPS);
  endfunction : crc15_step

  function automatic logic [14:0] crc15_block(input logic [DATA_W-1:0] data);
    logic [14:0] c;
    c = CRC_SEED;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      c = crc15_step(c, data[i]);
    end
    crc15_block = c;
  endfunction : crc15_block

  function automatic logic is_conv(input logic [10:0] code);
    is_conv = (code[10:9] == 2'h1) || (code[10:9] == 2'h2);
  endfunction : is_conv

  function automatic logic is_poll_kind(input logic [10:0] code);
    is_poll_kind = is_conv(code) || (code == CC_POLL_STATUS) || (code == CC_DIAG_POLL);
  endfunction : is_poll_kind

  function automatic logic is_read(input logic [10:0] code);
    is_read = ((code[10:5] == 6'h00) && !code[0]) || (code == CC_READ_COMM);
  endfunction : is_read

  function automatic logic is_write(input logic [10:0] code);
    is_write = (code == CC_WRITE_CFG) || (code == CC_WRITE_COMM);
  endfunction : is_write

endpackage : mcap_pkg

// ==== hw/mcap_sync.sv ====
// two-stage level synchroniser
// assumes the input is a level that stays put for several destination clocks
module mcap_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : mcap_sync

// ==== hw/mcap_crc15.sv ====
// serial 15-bit check code register, one bit per link clock
// assumes load_i marks the first bit of a run so the seed is folded in
module mcap_crc15 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic en_i,
  input wire logic bit_i,
  output logic [14:0] crc_nxt_o
);

  logic [14:0] crc_r;

  always_comb begin
    crc_nxt_o = mcap_pkg::crc15_step(load_i ? mcap_pkg::CRC_SEED : crc_r, bit_i);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_r <= mcap_pkg::CRC_SEED;
    end else if (en_i) begin
      crc_r <= crc_nxt_o;
    end
  end

endmodule : mcap_crc15

// ==== hw/mcap_link.sv ====
// command framing, addressing and conversion-status polling front end
// assumes the host owns link_clk_i and select_bar_i; the clock may stop between frames
// assumes read_data_i and the straps are quasi-static while a frame runs
module mcap_link (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic select_bar_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic poll_out_o,
  output logic reply_pulse_o,
  output logic chain_up_o,
  input wire logic chain_down_i,
  input wire logic address_pin_top_i,
  input wire logic [1:0] address_pin_mid_i,
  input wire logic address_pin_bottom_i,
  input wire logic isolated_link_select_i,
  input wire logic daisy_chain_select_i,
  input wire logic conv_busy_i,
  input wire logic [mcap_pkg::DATA_W-1:0] read_data_i,
  output logic conv_start_o,
  output logic cmd_strobe_o,
  output logic [10:0] cmd_code_o,
  output logic cmd_bcast_o,
  output logic pec_error_o,
  output logic wr_strobe_o,
  output logic [mcap_pkg::DATA_W-1:0] wr_data_o
);

  // ***************************************************************
  // straps, caught after reset release
  // ***************************************************************
  logic [5:0] strap_s;
  logic [1:0] strap_cnt_r;
  mcap_pkg::mcap_strap_t strap_r;

  mcap_sync #(.W(6), .RST_VAL(6'h00)) u_strap_sync (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .d_i({isolated_link_select_i, daisy_chain_select_i, address_pin_top_i,
          address_pin_mid_i, address_pin_bottom_i}),
    .q_o(strap_s)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_cnt_r <= 2'h0;
      strap_r <= '0;
    end else if (strap_cnt_r != mcap_pkg::STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_r <= strap_s;
    end
  end

  // ***************************************************************
  // link domain: bit counting and command capture
  // ***************************************************************
  logic frame_rst;
  logic in_frame_l;
  logic first_bit;
  logic [7:0] cnt_l;
  logic [7:0] idx;
  logic [31:0] cmd_sh_l;
  logic [31:0] full_w;
  logic [14:0] crc_nxt;
  logic [14:0] exp_l;
  logic [mcap_pkg::GROUP_W-1:0] win_l;
  logic [mcap_pkg::GROUP_W-1:0] tx_l;
  mcap_pkg::mcap_cmd_t cmd_w;
  mcap_pkg::mcap_cmd_t cmd_l;
  mcap_pkg::mcap_dec_t dec_w;
  mcap_pkg::mcap_dec_t dec_l;
  logic bcast_ok;
  logic addr_match;
  logic tgl_l;
  logic rd_l;
  logic poll_l;
  logic busy_l;
  logic busy_r;

  // the frame's own select ends everything that must not outlive it
  assign frame_rst = sys_rst_i | select_bar_i;
  assign first_bit = ~in_frame_l;
  assign idx = first_bit ? 8'h00 : cnt_l;

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      in_frame_l <= 1'b0;
    end else begin
      in_frame_l <= 1'b1;
    end
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_l <= 8'h00;
    end else if (idx != mcap_pkg::CNT_MAX) begin
      cnt_l <= idx + 8'h01;
    end
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_sh_l <= 32'h0;
    end else if (idx <= mcap_pkg::CNT_CMD_LAST) begin
      cmd_sh_l <= {cmd_sh_l[30:0], serial_in_i};
    end
  end

  mcap_crc15 u_crc (
    .clk_i(link_clk_i),
    .rst_i(sys_rst_i),
    .load_i(first_bit),
    .en_i(idx <= mcap_pkg::CNT_CMD_B1_LAST),
    .bit_i(serial_in_i),
    .crc_nxt_o(crc_nxt)
  );

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exp_l <= mcap_pkg::CRC_SEED;
    end else if (idx == mcap_pkg::CNT_CMD_B1_LAST) begin
      exp_l <= crc_nxt;
    end
  end

  always_comb begin
    full_w = {cmd_sh_l[30:0], serial_in_i};
    cmd_w.addressed = full_w[mcap_pkg::POS_ADDR_FLAG];
    cmd_w.addr = full_w[mcap_pkg::POS_ADDR_HI:mcap_pkg::POS_ADDR_LO];
    cmd_w.code = full_w[mcap_pkg::POS_CODE_HI:mcap_pkg::POS_CODE_LO];
    bcast_ok = (full_w[mcap_pkg::POS_ADDR_FLAG:mcap_pkg::POS_ADDR_LO] == 5'h00);
    addr_match = cmd_w.addressed && (cmd_w.addr == strap_r.addr);
    dec_w.chk_ok = (full_w[mcap_pkg::POS_CHK_HI:0] == {exp_l, 1'b0});
    if (strap_r.chain) begin
      dec_w.accepted = dec_w.chk_ok && bcast_ok;
    end else begin
      dec_w.accepted = dec_w.chk_ok && (bcast_ok || addr_match);
    end
    dec_w.reply_ok = dec_w.accepted &&
                     (strap_r.chain || addr_match || !strap_r.iso);
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_l <= '0;
      dec_l <= '0;
      tgl_l <= 1'b0;
      tx_l <= '0;
    end else if (idx == mcap_pkg::CNT_CMD_LAST) begin
      cmd_l <= cmd_w;
      dec_l <= dec_w;
      tgl_l <= ~tgl_l;
      tx_l <= {read_data_i, mcap_pkg::crc15_block(read_data_i), 1'b0};
    end
  end

  // last eight bytes after the command; a chain device keeps the block
  // that arrives last, the others having been shifted on upward
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_l <= '0;
    end else if (idx >= mcap_pkg::CNT_DATA_FIRST) begin
      win_l <= {win_l[mcap_pkg::GROUP_W-2:0], serial_in_i};
    end
  end

  // ***************************************************************
  // link domain: per-frame reply state
  // ***************************************************************
  mcap_sync #(.W(1), .RST_VAL(1'b0)) u_busy_sync (
    .clk_i(link_clk_i),
    .rst_i(sys_rst_i),
    .d_i(busy_r),
    .q_o(busy_l)
  );

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      rd_l <= 1'b0;
      poll_l <= 1'b0;
    end else if (idx == mcap_pkg::CNT_CMD_LAST) begin
      rd_l <= dec_w.reply_ok && mcap_pkg::is_read(cmd_w.code);
      poll_l <= dec_w.reply_ok && !strap_r.chain && strap_r.iso &&
                mcap_pkg::is_poll_kind(cmd_w.code);
    end
  end

  // one answer per master pulse, only while still converting
  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      reply_pulse_o <= 1'b0;
    end else begin
      reply_pulse_o <= poll_l && busy_l;
    end
  end

  // falling edge so the next device sees each bit at the following rising edge
  always_ff @(negedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      chain_up_o <= 1'b1;
    end else begin
      chain_up_o <= strap_r.chain ? serial_in_i : 1'b1;
    end
  end

  always_ff @(negedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      serial_out_o <= 1'b1;
    end else if (rd_l && (cnt_l >= mcap_pkg::CNT_DATA_FIRST)) begin
      if (cnt_l < mcap_pkg::CNT_GROUP_END) begin
        serial_out_o <= tx_l[6'(mcap_pkg::CNT_TX_LAST - cnt_l)];
      end else begin
        serial_out_o <= strap_r.chain ? chain_down_i : 1'b1;
      end
    end else begin
      serial_out_o <= 1'b1;
    end
  end

  // ***************************************************************
  // system domain: crossings
  // ***************************************************************
  logic sel_s;
  logic sel_d;
  logic sel_rise;
  logic tgl_s;
  logic tgl_d;
  logic cmd_ev;

  mcap_sync #(.W(1), .RST_VAL(1'b1)) u_sel_sync (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .d_i(select_bar_i),
    .q_o(sel_s)
  );

  mcap_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .d_i(tgl_l),
    .q_o(tgl_s)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_d <= 1'b1;
      tgl_d <= 1'b0;
    end else begin
      sel_d <= sel_s;
      tgl_d <= tgl_s;
    end
  end

  assign sel_rise = sel_s & ~sel_d;
  assign cmd_ev = tgl_s ^ tgl_d;

  // ***************************************************************
  // system domain: command events
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_strobe_o <= 1'b0;
      pec_error_o <= 1'b0;
      conv_start_o <= 1'b0;
      cmd_code_o <= 11'h000;
      cmd_bcast_o <= 1'b0;
    end else begin
      cmd_strobe_o <= cmd_ev && dec_l.accepted;
      pec_error_o <= cmd_ev && !dec_l.chk_ok;
      conv_start_o <= cmd_ev && dec_l.accepted && mcap_pkg::is_conv(cmd_l.code);
      if (cmd_ev && dec_l.accepted) begin
        cmd_code_o <= cmd_l.code;
        cmd_bcast_o <= !cmd_l.addressed;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= conv_busy_i || conv_start_o;
    end
  end

  // ***************************************************************
  // system domain: status polling
  // ***************************************************************
  mcap_pkg::mcap_poll_t poll_st_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      poll_st_r <= mcap_pkg::ST_IDLE;
    end else begin
      case (poll_st_r)
        mcap_pkg::ST_IDLE: begin
          if (cmd_ev && !sel_s && dec_l.reply_ok && !strap_r.chain &&
              mcap_pkg::is_poll_kind(cmd_l.code)) begin
            poll_st_r <= strap_r.iso ? mcap_pkg::ST_ISO_POLL : mcap_pkg::ST_SPI_POLL;
          end
        end
        mcap_pkg::ST_SPI_POLL: begin
          if (sel_s) begin
            poll_st_r <= mcap_pkg::ST_IDLE;
          end
        end
        mcap_pkg::ST_ISO_POLL: begin
          if (sel_s) begin
            poll_st_r <= mcap_pkg::ST_IDLE;
          end
        end
        default: begin
          poll_st_r <= mcap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // select high forces the level high at once, without waiting for the clock
  always_ff @(posedge ref_clk_i or posedge sys_rst_i or posedge select_bar_i) begin
    if (sys_rst_i) begin
      poll_out_o <= 1'b1;
    end else if (select_bar_i) begin
      poll_out_o <= 1'b1;
    end else begin
      poll_out_o <= !((poll_st_r == mcap_pkg::ST_SPI_POLL) && busy_r);
    end
  end

  // ***************************************************************
  // system domain: write latch at end of frame
  // ***************************************************************
  logic wr_len_ok;
  logic wr_chk_ok;
  logic wr_arm_r;

  always_comb begin
    if (strap_r.chain) begin
      wr_len_ok = (cnt_l >= mcap_pkg::CNT_GROUP_END);
    end else begin
      wr_len_ok = (cnt_l == mcap_pkg::CNT_GROUP_END);
    end
    wr_chk_ok = (win_l[15:0] ==
                 {mcap_pkg::crc15_block(win_l[mcap_pkg::GROUP_W-1:16]), 1'b0});
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_strobe_o <= 1'b0;
      wr_data_o <= '0;
      wr_arm_r <= 1'b0;
    end else begin
      wr_strobe_o <= 1'b0;
      // a select toggle with no clocks must not latch the old frame again
      if (sel_rise) begin
        wr_arm_r <= 1'b0;
      end
      if (cmd_ev) begin
        wr_arm_r <= 1'b1;
      end
      if (sel_rise && wr_arm_r && dec_l.accepted && mcap_pkg::is_write(cmd_l.code) &&
          wr_len_ok && wr_chk_ok) begin
        wr_strobe_o <= 1'b1;
        wr_data_o <= win_l[mcap_pkg::GROUP_W-1:16];
      end
    end
  end

endmodule : mcap_link

// ==== tb/mcap_monitor.sv ====
// port checks for the command front end
// assumes it is bound onto every mcap_link instance
module mcap_monitor (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic select_bar_i,
  input wire logic poll_out_o,
  input wire logic reply_pulse_o,
  input wire logic chain_up_o,
  input wire logic isolated_link_select_i,
  input wire logic daisy_chain_select_i,
  input wire logic conv_busy_i,
  input wire logic conv_start_o,
  input wire logic cmd_strobe_o,
  input wire logic cmd_bcast_o,
  input wire logic pec_error_o,
  input wire logic wr_strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***************************************************************
  // assertions
  // ***************************************************************
  a_select_poll_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    select_bar_i |-> poll_out_o) else $error("poll level low while deselected");
  a_poll_busy_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(poll_out_o) |-> select_bar_i || !$past(conv_busy_i)) else $error("poll rose while busy");
  a_strobe_single: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_strobe_o |=> !cmd_strobe_o) else $error("command strobe longer than one cycle");
  a_conv_single: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    conv_start_o |=> !conv_start_o) else $error("conversion start longer than one cycle");
  a_pec_no_accept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    pec_error_o |-> !cmd_strobe_o && !conv_start_o) else $error("bad check code accepted");
  a_chain_bcast_only: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    daisy_chain_select_i && cmd_strobe_o |=> cmd_bcast_o) else $error("chain took addressed");
  a_write_after_rise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_strobe_o |-> select_bar_i && $past(select_bar_i)) else $error("write before select rise");
  a_chain_up_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !daisy_chain_select_i |-> chain_up_o) else $error("chain output active outside chain");
  a_reply_iso_only: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    reply_pulse_o |-> isolated_link_select_i && !select_bar_i) else $error("stray reply pulse");
  c_write: cover property (@(posedge ref_clk_i) wr_strobe_o);
  c_pec: cover property (@(posedge ref_clk_i) pec_error_o);
  c_reply: cover property (@(posedge link_clk_i) reply_pulse_o);
endmodule : mcap_monitor

bind mcap_link mcap_monitor mcap_monitor_inst (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
  .select_bar_i(select_bar_i), .poll_out_o(poll_out_o), .reply_pulse_o(reply_pulse_o),
  .chain_up_o(chain_up_o), .isolated_link_select_i(isolated_link_select_i),
  .daisy_chain_select_i(daisy_chain_select_i), .conv_busy_i(conv_busy_i),
  .conv_start_o(conv_start_o), .cmd_strobe_o(cmd_strobe_o), .cmd_bcast_o(cmd_bcast_o),
  .pec_error_o(pec_error_o), .wr_strobe_o(wr_strobe_o)
);

// ==== tb/mcap_host_model.sv ====
// host side of the serial link: frames bits msb first, samples the return line
// assumes the caller composes whole frames; link clock stands still between frames
module mcap_host_model (
  output logic link_clk_o,
  output logic select_bar_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk_o = 1'b0;
    select_bar_o = 1'b1;
    mosi_o = 1'b1;
  end
  // shifts n bits, leaves select low so a frame may be continued
  task automatic shift(input logic [159:0] bits, input int n, output logic [159:0] got);
    got = '0;
    #7;
    select_bar_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = bits[i];
      #32;
      got = {got[158:0], miso_i};
      link_clk_o = 1'b1;
      #32;
      link_clk_o = 1'b0;
    end
  endtask : shift
  // released data line shows the inverse of its last value
  task automatic release_sel;
    #32;
    select_bar_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : release_sel
endmodule : mcap_host_model

// ==== tb/testbench.sv ====
// self-checking bench for mcap_link against a behavioural host
// assumes 25 MHz system clock and a 64 ns link clock from the host model
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, conv_busy = 1'b0, iso = 1'b0, chain = 1'b0;
  logic [3:0] addr = 4'ha;
  logic [47:0] read_data = 48'h0123_4567_89ab;
  logic link_clk, select_bar, serial_in, serial_out, poll_out, reply_pulse, chain_up;
  logic conv_start, cmd_strobe, cmd_bcast, pec_error, wr_strobe;
  logic [10:0] cmd_code;
  logic [47:0] wr_data;
  logic [159:0] got;
  int n_fail = 0, comparisons = 0, n_cmd = 0, n_conv = 0, n_pec = 0, n_wr = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_cmd += (cmd_strobe === 1'b1);
    n_conv += (conv_start === 1'b1);
    n_pec += (pec_error === 1'b1);
    n_wr += (wr_strobe === 1'b1);
  end
  mcap_host_model mcap_host_model_inst (.link_clk_o(link_clk), .select_bar_o(select_bar),
    .mosi_o(serial_in), .miso_i(iso ? reply_pulse : (serial_out & poll_out)));
  mcap_link mcap_link_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .link_clk_i(link_clk),
    .select_bar_i(select_bar), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .poll_out_o(poll_out), .reply_pulse_o(reply_pulse), .chain_up_o(chain_up),
    .chain_down_i(chain_up), .address_pin_top_i(addr[3]), .address_pin_mid_i(addr[2:1]),
    .address_pin_bottom_i(addr[0]), .isolated_link_select_i(iso),
    .daisy_chain_select_i(chain), .conv_busy_i(conv_busy), .read_data_i(read_data),
    .conv_start_o(conv_start), .cmd_strobe_o(cmd_strobe), .cmd_code_o(cmd_code),
    .cmd_bcast_o(cmd_bcast), .pec_error_o(pec_error), .wr_strobe_o(wr_strobe),
    .wr_data_o(wr_data));
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [15:0] packet_check_code(input logic [47:0] d, input int n);
    logic [14:0] c;
    logic f;
    c = mcap_pkg::CRC_SEED;
    for (int i = n - 1; i >= 0; i--) begin
      f = d[i] ^ c[14];
      c = {c[13:0], 1'b0} ^ ({15{f}} & 15'h4599);
    end
    return {c, 1'b0};
  endfunction : packet_check_code
  function automatic logic [31:0] cmd(input logic a, input logic [3:0] ad, input logic [10:0] cc);
    logic [15:0] w;
    w = {a, a ? ad : 4'h0, cc};
    return {w, packet_check_code({32'h0, w}, 16)};
  endfunction : cmd
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic start(input logic i, input logic c);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    iso <= i;
    chain <= c;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : start
  task automatic send(input logic [159:0] bits, input int n);
    mcap_host_model_inst.shift(bits, n, got);
    mcap_host_model_inst.release_sel;
    repeat (12) @(posedge ref_clk);
  endtask : send
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_addressing;
    int c0;
    check("pec of 0001", packet_check_code(48'h1, 16), 16'h3d6e);
    c0 = n_cmd;
    send(cmd(1'b1, addr, 11'h711), 32);
    check("match strobe", n_cmd - c0, 1);
    check("match code", cmd_code, 11'h711);
    check("match bcast", cmd_bcast, 1'b0);
    send(cmd(1'b1, ~addr, 11'h711), 32);
    check("other addr", n_cmd - c0, 1);
    send(cmd(1'b0, 4'h0, 11'h712), 32);
    check("bcast strobe", n_cmd - c0, 2);
    check("bcast code", {cmd_bcast, cmd_code}, {1'b1, 11'h712});
    c0 = n_pec;
    send(cmd(1'b1, addr, 11'h711) ^ 32'h4, 32);
    check("bad check code", n_pec - c0, 1);
  endtask : t_addressing
  task automatic t_read_write;
    int w0;
    send({64'h0, cmd(1'b1, addr, 11'h004), 64'hffff_0000_ffff_0000}, 96);
    check("read reply", got[63:0], {read_data, packet_check_code(read_data, 48)});
    send({64'h0, cmd(1'b1, ~addr, 11'h004), 64'h0}, 96);
    check("silent reply", got[63:0], {64{1'b1}});
    w0 = n_wr;
    mcap_host_model_inst.shift({64'h0, cmd(1'b1, addr, 11'h001), 48'hfedc_ba98_7654,
      packet_check_code(48'hfedc_ba98_7654, 48)}, 96, got);
    repeat (8) @(posedge ref_clk);
    check("write early", n_wr - w0, 0);
    send(0, 0);
    check("write strobe", n_wr - w0, 1);
    check("write data", wr_data, 48'hfedc_ba98_7654);
    send(0, 0);
    check("write once", n_wr - w0, 1);
  endtask : t_read_write
  task automatic t_poll;
    int v0;
    v0 = n_conv;
    @(posedge ref_clk) conv_busy <= 1'b1;
    mcap_host_model_inst.shift({128'h0, cmd(1'b1, addr, 11'h360)}, 32, got);
    repeat (8) @(posedge ref_clk);
    check("poll busy", poll_out, 1'b0);
    check("conv start", n_conv - v0, 1);
    @(posedge ref_clk) conv_busy <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("poll done", poll_out, 1'b1);
    conv_busy <= 1'b1;
    send(0, 0);
    mcap_host_model_inst.shift({128'h0, cmd(1'b1, addr, mcap_pkg::CC_POLL_STATUS)}, 32, got);
    repeat (8) @(posedge ref_clk);
    check("status poll busy", poll_out, 1'b0);
    mcap_host_model_inst.release_sel;
    #5;
    check("poll on deselect", poll_out, 1'b1);
    repeat (12) @(posedge ref_clk);
    mcap_host_model_inst.shift({128'h0, cmd(1'b1, ~addr, 11'h360)}, 32, got);
    repeat (8) @(posedge ref_clk);
    check("other poll", poll_out, 1'b1);
    send(0, 0);
    @(posedge ref_clk) conv_busy <= 1'b0;
  endtask : t_poll
  task automatic t_iso;
    int v0;
    start(1'b1, 1'b0);
    @(posedge ref_clk) conv_busy <= 1'b1;
    mcap_host_model_inst.shift({120'h0, cmd(1'b1, addr, 11'h360), 8'hff}, 40, got);
    check("iso busy pulses", got[3:0], 4'hf);
    @(posedge ref_clk) conv_busy <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mcap_host_model_inst.shift(160'hff, 8, got);
    check("iso done", got[3:0], 4'h0);
    send(0, 0);
    @(posedge ref_clk) conv_busy <= 1'b1;
    mcap_host_model_inst.shift(160'hff, 8, got);
    check("iso after exit", got[7:0], 8'h0);
    send(0, 0);
    v0 = n_conv;
    mcap_host_model_inst.shift({120'h0, cmd(1'b0, 4'h0, 11'h360), 8'hff}, 40, got);
    check("iso bcast", got[7:0], 8'h0);
    send(0, 0);
    check("iso bcast conv", n_conv - v0, 1);
    @(posedge ref_clk) conv_busy <= 1'b0;
  endtask : t_iso
  task automatic t_chain;
    int c0;
    start(1'b0, 1'b1);
    c0 = n_cmd;
    send(cmd(1'b1, addr, 11'h711), 32);
    check("chain addressed", n_cmd - c0, 0);
    send({cmd(1'b0, 4'h0, mcap_pkg::CC_WRITE_COMM), 48'h1111_2222_3333,
      packet_check_code(48'h1111_2222_3333, 48),
      48'h0a0b_0c0d_0e0f, packet_check_code(48'h0a0b_0c0d_0e0f, 48)}, 160);
    check("chain write", wr_data, 48'h0a0b_0c0d_0e0f);
    // fixed wait instead of polling a chain
    send({cmd(1'b0, 4'h0, mcap_pkg::CC_READ_COMM), 128'h0}, 160);
    check("chain own", got[127:64], {read_data, packet_check_code(read_data, 48)});
    check("chain passed", got[63:0], 64'h0);
  endtask : t_chain
  initial begin
    start(1'b0, 1'b0);
    t_addressing;
    t_read_write;
    t_poll;
    t_iso;
    t_chain;
    summarize;
  end
  initial begin
    #3ms;
    n_fail++;
    summarize;
  end
endmodule : testbench
